// ==== core/crbc_rx_ctrl.sv ====
// Overview of operation
// - when enabled, pulse frame_start_out at each detected CAN message start
// - on idle bus, falling edge counts only if dominant holds to sample point
// - dominant lost before sample point is a glitch, no start pulse
// - pin function disabled puts buffer-full pin in high impedance
// - interrupt mode: pin active low, mirrors the buffer's receive flag
// - flag cleared by host: pin returns high until next message loads
// - digital output mode: pin drives the stored level bit
// - level bit reads zero while its pin is an enabled interrupt pin
// - mode 11 takes any message, 00 filters, 01 and 10 reserved
// - buffer 0 mode 00 applies extended filter bytes to first data bytes
// - remote request bit shows whether the stored message was remote
// - rollover enabled, buffer 0 full and buffer 1 free: message goes to buffer 1
// - buffer 0 shows a read-only copy of the rollover enable
// - buffer 0 hit bit tells filter 1 from filter 0
// - rolled over message still shows its buffer 0 filter in hit bit
// - buffer 1 hit code holds accepting filter, 0 and 1 only on rollover
// - unimplemented bits in the control registers read as zero
// - load sets receive flag; host must clear it before next load
`include "crbc_cfg.svh"
`timescale 1ns/10ps
module crbc_rx_ctrl (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // can receive pin and bit timing from the protocol engine
   input  wire logic                can_rx_in,
   input  wire logic                bus_idle,
   input  wire logic                sample_point,
   input  wire logic                sof_en,
   // start-of-frame output
   output logic                     frame_start_out,
   output logic                     glitch_seen,
   // register port from the serial command decoder
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic [7:0]          reg_wmask,
   output logic      [7:0]          reg_rdata,
   // accepted message from the acceptance filters
   input  wire logic                msg_valid,
   input  wire logic                msg_for_buf0,
   input  wire crbc_pkg::crbc_filt_t msg_filter,
   input  wire logic                msg_rtr,
   // receive flags held in the interrupt flag register
   input  wire logic                rx_flag0,
   input  wire logic                rx_flag1,
   // buffer load strobes and mode outputs
   output logic                     load_buf0,
   output logic                     load_buf1,
   output logic                     msg_dropped,
   output crbc_pkg::crbc_mode_t     rx_mode0,
   output crbc_pkg::crbc_mode_t     rx_mode1,
   output logic                     accept_any0,
   output logic                     accept_any1,
   output logic                     data_byte_filt,
   // buffer-full pins, active low in interrupt mode
   output logic                     buf0_full_out,
   output logic                     buf0_full_oe,
   output logic                     buf1_full_out,
   output logic                     buf1_full_oe
);

   // register state
   logic [1:0]                pin_func_en;
   logic [1:0]                pin_op_sel;
   logic [1:0]                pin_level;
   logic                      rollover_en;
   logic [1:0]                remote_req_seen;
   logic                      hit_filter_lsb;
   crbc_pkg::crbc_filt_t      hit_filter_code;
   crbc_pkg::crbc_sof_state_t sof_state;
   logic                      rx_meta;
   logic                      rx_sync;
   logic                      rx_prev;
   logic [1:0]                flag;
   logic [7:0]                next_data;
   logic [7:0]                pin_ctrl_rd;
   logic [7:0]                buf0_ctrl_rd;
   logic [7:0]                buf1_ctrl_rd;
   logic                      go_buf0;
   logic                      go_buf1;
   logic [7:0]                next_buf0;
   logic [7:0]                next_buf1;

   // reset image kept as a constant so its fields can be sliced
   localparam logic [7:0] PIN_CTRL_RST = `CRBC_RST_PIN_CTRL;

   assign flag = {rx_flag1, rx_flag0};

   // two-flop synchroniser on the pin; rx_sync and its delayed copy rx_prev are looked at
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= can_rx_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   // start-of-frame detector with glitch rejection
   always_ff @(posedge clk) begin
      if (srst) begin
         sof_state       <= crbc_pkg::CRBC_SOF_IDLE;
         frame_start_out <= 1'b0;
         glitch_seen     <= 1'b0;
      end else begin
         frame_start_out <= 1'b0;
         glitch_seen     <= 1'b0;
         case (sof_state)
            crbc_pkg::CRBC_SOF_IDLE: begin
               if (bus_idle && rx_prev && !rx_sync) begin
                  sof_state <= crbc_pkg::CRBC_SOF_WAIT_SP;
               end
            end
            crbc_pkg::CRBC_SOF_WAIT_SP: begin
               if (rx_sync) begin
                  // back to recessive before sampling: a glitch
                  glitch_seen <= 1'b1;
                  sof_state   <= crbc_pkg::CRBC_SOF_IDLE;
               end else if (sample_point) begin
                  frame_start_out <= sof_en;
                  sof_state       <= crbc_pkg::CRBC_SOF_BUSY;
               end
            end
            crbc_pkg::CRBC_SOF_BUSY: begin
               // wait for the engine to leave idle, so one frame
               // never gives two pulses
               if (!bus_idle) begin
                  sof_state <= crbc_pkg::CRBC_SOF_IDLE;
               end
            end
            default: begin
               sof_state <= crbc_pkg::CRBC_SOF_IDLE;
            end
         endcase
      end
   end

   // destination choice; a full buffer is never overwritten
   always_comb begin
      go_buf0 = 1'b0;
      go_buf1 = 1'b0;
      if (msg_valid) begin
         if (msg_for_buf0) begin
            go_buf0 = !flag[0];
            go_buf1 = flag[0] && rollover_en && !flag[1];
         end else begin
            go_buf1 = !flag[1];
         end
      end
   end

   // load strobes; the flag register sets its flag on these
   always_ff @(posedge clk) begin
      if (srst) begin
         load_buf0   <= 1'b0;
         load_buf1   <= 1'b0;
         msg_dropped <= 1'b0;
      end else begin
         load_buf0   <= go_buf0;
         load_buf1   <= go_buf1;
         msg_dropped <= msg_valid && !go_buf0 && !go_buf1;
      end
   end

   // status captured with each stored message
   always_ff @(posedge clk) begin
      if (srst) begin
         remote_req_seen <= 2'h0;
         hit_filter_lsb  <= 1'b0;
         hit_filter_code <= `CRBC_RST_HIT;
      end else begin
         if (go_buf0) begin
            remote_req_seen[0] <= msg_rtr;
            hit_filter_lsb     <= msg_filter[0];
         end
         if (go_buf1) begin
            remote_req_seen[1] <= msg_rtr;
            // rolled over messages keep their own filter number,
            // so codes 0 and 1 only ever appear through rollover
            hit_filter_code <= msg_filter;
            if (msg_for_buf0) begin
               hit_filter_lsb <= msg_filter[0];
            end
         end
      end
   end

   // masked update shared by write and bit-modify
   function automatic logic [7:0] crbc_merge(input logic [7:0] old_v);
      crbc_merge = (old_v & ~reg_wmask) | (reg_wdata & reg_wmask);
   endfunction

   // merged images of each register, read-only bits dropped later
   assign next_data = crbc_merge({2'h0, pin_level, pin_func_en,
                                  pin_op_sel});
   assign next_buf0 = crbc_merge(buf0_ctrl_rd);
   assign next_buf1 = crbc_merge(buf1_ctrl_rd);

   // pin control register; writable fields only
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_op_sel  <= PIN_CTRL_RST[`CRBC_POS_OP_SEL +: 2];
         pin_func_en <= PIN_CTRL_RST[`CRBC_POS_FUNC_EN +: 2];
         pin_level   <= PIN_CTRL_RST[`CRBC_POS_LEVEL +: 2];
      end else if (reg_wr && reg_addr == `CRBC_OFS_PIN_CTRL) begin
         // the mask lets the host touch one pin without
         // glitching the other
         pin_op_sel  <= next_data[`CRBC_POS_OP_SEL +: 2];
         pin_func_en <= next_data[`CRBC_POS_FUNC_EN +: 2];
         pin_level   <= next_data[`CRBC_POS_LEVEL +: 2];
      end
   end

   // receive mode and rollover fields; status bits not writable
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_mode0    <= `CRBC_RST_MODE;
         rx_mode1    <= `CRBC_RST_MODE;
         rollover_en <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == `CRBC_OFS_BUF0_CTRL) begin
            rx_mode0    <= next_buf0[`CRBC_POS_MODE +: 2];
            rollover_en <= next_buf0[`CRBC_POS_ROLL_EN];
         end
         if (reg_addr == `CRBC_OFS_BUF1_CTRL) begin
            rx_mode1 <= next_buf1[`CRBC_POS_MODE +: 2];
         end
      end
   end

   // mode decode for the filter logic
   always_ff @(posedge clk) begin
      if (srst) begin
         accept_any0    <= 1'b0;
         accept_any1    <= 1'b0;
         data_byte_filt <= 1'b0;
      end else begin
         // reserved modes fall back to filtering
         accept_any0    <= rx_mode0 == `CRBC_MODE_ANY;
         accept_any1    <= rx_mode1 == `CRBC_MODE_ANY;
         data_byte_filt <= rx_mode0 == `CRBC_MODE_FILTER;
      end
   end

   // read views; unimplemented bits are zero
   always_comb begin
      pin_ctrl_rd = 8'h00;
      pin_ctrl_rd[`CRBC_POS_OP_SEL +: 2]  = pin_op_sel;
      pin_ctrl_rd[`CRBC_POS_FUNC_EN +: 2] = pin_func_en;
      // only an enabled interrupt pin hides its level bit
      pin_ctrl_rd[`CRBC_POS_LEVEL +: 2]   = pin_level &
                                            ~(pin_op_sel & pin_func_en);
      buf0_ctrl_rd = 8'h00;
      buf0_ctrl_rd[`CRBC_POS_MODE +: 2]   = rx_mode0;
      buf0_ctrl_rd[`CRBC_POS_RTR]         = remote_req_seen[0];
      buf0_ctrl_rd[`CRBC_POS_ROLL_EN]     = rollover_en;
      buf0_ctrl_rd[`CRBC_POS_ROLL_COPY]   = rollover_en;
      buf0_ctrl_rd[`CRBC_POS_HIT]         = hit_filter_lsb;
      buf1_ctrl_rd = 8'h00;
      buf1_ctrl_rd[`CRBC_POS_MODE +: 2]   = rx_mode1;
      buf1_ctrl_rd[`CRBC_POS_RTR]         = remote_req_seen[1];
      buf1_ctrl_rd[`CRBC_POS_HIT +: 3]    = hit_filter_code;
   end

   // registered read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `CRBC_OFS_PIN_CTRL:  reg_rdata <= pin_ctrl_rd;
            `CRBC_OFS_BUF0_CTRL: reg_rdata <= buf0_ctrl_rd;
            `CRBC_OFS_BUF1_CTRL: reg_rdata <= buf1_ctrl_rd;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // buffer-full pins; level and enable both from flops
   always_ff @(posedge clk) begin
      if (srst) begin
         buf0_full_out <= 1'b1;
         buf0_full_oe  <= 1'b0;
         buf1_full_out <= 1'b1;
         buf1_full_oe  <= 1'b0;
      end else begin
         buf0_full_oe  <= pin_func_en[0];
         buf1_full_oe  <= pin_func_en[1];
         // interrupt mode follows the flag both ways, so a host
         // clear releases the pin one clock after the flag drops
         buf0_full_out <= pin_op_sel[0] ? !flag[0]
                                        : pin_level[0];
         buf1_full_out <= pin_op_sel[1] ? !flag[1]
                                        : pin_level[1];
      end
   end

endmodule // crbc_rx_ctrl

// ==== pkg/crbc_cfg.svh ====
`ifndef CRBC_CFG_SVH
`define CRBC_CFG_SVH
// register offsets
`define CRBC_OFS_PIN_CTRL   8'h0C
`define CRBC_OFS_BUF0_CTRL  8'h60
`define CRBC_OFS_BUF1_CTRL  8'h70
// pin control field positions
`define CRBC_POS_OP_SEL     0
`define CRBC_POS_FUNC_EN    2
`define CRBC_POS_LEVEL      4
// buffer control field positions
`define CRBC_POS_HIT        0
`define CRBC_POS_ROLL_COPY  1
`define CRBC_POS_ROLL_EN    2
`define CRBC_POS_RTR        3
`define CRBC_POS_MODE       5
// reset values
`define CRBC_RST_PIN_CTRL   8'h00
`define CRBC_RST_MODE       2'h0
`define CRBC_RST_HIT        3'h0
// receive mode encodings
`define CRBC_MODE_FILTER    2'h0
`define CRBC_MODE_ANY       2'h3
`endif

// ==== pkg/crbc_pkg.sv ====
package crbc_pkg;
   // start-of-frame detector states
   typedef enum logic [1:0] {
      CRBC_SOF_IDLE,
      CRBC_SOF_WAIT_SP,
      CRBC_SOF_BUSY
   } crbc_sof_state_t;
   // receive mode field
   typedef logic [1:0] crbc_mode_t;
   // filter number, 0 to 5
   typedef logic [2:0] crbc_filt_t;
endpackage

// ==== verif/crbc_flag_model.sv ====
`timescale 1ns/10ps
module crbc_flag_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // load strobes from the block, clear requests from the host
   input  wire logic load_buf0,
   input  wire logic load_buf1,
   input  wire logic clr0,
   input  wire logic clr1,
   // receive flags back to the block
   output logic      rx_flag0,
   output logic      rx_flag1
);
   // a load sets a flag; only the host clears it, so a full buffer locks
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_flag0 <= 1'h0;
         rx_flag1 <= 1'h0;
      end else begin
         rx_flag0 <= load_buf0 | (rx_flag0 & ~clr0);
         rx_flag1 <= load_buf1 | (rx_flag1 & ~clr1);
      end
   end
endmodule // crbc_flag_model

// ==== verif/crbc_rx_ctrl_sva.sv ====
`timescale 1ns/10ps
module crbc_rx_ctrl_chk (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // register writes
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_wmask,
   // message path
   input  wire logic       msg_valid,
   input  wire logic       msg_for_buf0,
   input  wire logic       rx_flag0,
   input  wire logic       rx_flag1,
   input  wire logic       load_buf0,
   input  wire logic       load_buf1,
   input  wire logic       msg_dropped,
   // start of frame
   input  wire logic       sample_point,
   input  wire logic       sof_en,
   input  wire logic       frame_start_out,
   // buffer-full pins
   input  wire logic       buf0_full_oe,
   input  wire logic       buf0_full_out,
   input  wire logic       buf1_full_out
);
   logic [7:0] pc;
   logic       rb;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // shadow of pin control and rollover enable, built from masked writes
   always_ff @(posedge clk) begin
      if (srst) begin
         pc <= 8'h00;
         rb <= 1'h0;
      end else if (reg_wr) begin
         if (reg_addr == 8'h0C) begin
            pc <= (pc & ~reg_wmask) | (reg_wdata & reg_wmask);
         end
         if (reg_addr == 8'h60 && reg_wmask[2]) rb <= reg_wdata[2];
      end
   end
   pin_enable_a: assert property (buf0_full_oe == $past(pc[2]))
      else $error("pin 0 enable wrong");
   pin_irq_a: assert property ($past(pc[2] & pc[0]) |->
      buf0_full_out == !$past(rx_flag0)) else $error("pin 0 not flag");
   pin_level_a: assert property ($past(pc[3] & !pc[1]) |->
      buf1_full_out == $past(pc[5])) else $error("pin 1 not level");
   load_one_a: assert property (msg_valid |=>
      $onehot({load_buf0, load_buf1, msg_dropped})) else $error("no answer");
   load_idle_a: assert property (!msg_valid |=>
      !(load_buf0 || load_buf1 || msg_dropped)) else $error("stray load");
   buf0_free_a: assert property (msg_valid && msg_for_buf0 && !rx_flag0
      |=> load_buf0) else $error("buffer 0 not loaded");
   roll_over_a: assert property (msg_valid && msg_for_buf0 && rx_flag0
      && rb && !rx_flag1 |=> load_buf1) else $error("no rollover");
   no_roll_a: assert property (msg_valid && msg_for_buf0 && rx_flag0
      && !rb |=> msg_dropped) else $error("rollover while off");
   buf1_route_a: assert property (msg_valid && !msg_for_buf0 |=>
      load_buf1 == !$past(rx_flag1)) else $error("buffer 1 route");
   sof_cause_a: assert property (frame_start_out |->
      $past(sample_point) && $past(sof_en)) else $error("stray start");
endmodule // crbc_rx_ctrl_chk

bind crbc_rx_ctrl crbc_rx_ctrl_chk chk (.clk, .srst, .reg_wr, .reg_addr,
   .reg_wdata, .reg_wmask, .msg_valid, .msg_for_buf0, .rx_flag0, .rx_flag1,
   .load_buf0, .load_buf1, .msg_dropped, .sample_point, .sof_en,
   .frame_start_out, .buf0_full_oe, .buf0_full_out, .buf1_full_out);

// ==== verif/crbc_rx_ctrl_tb.sv ====
`timescale 1ns/10ps
module crbc_rx_ctrl_tb;
   logic clk = 1'h0, srst = 1'h1, can_rx_in = 1'h1, bus_idle = 1'h1;
   logic sample_point = 1'h0, sof_en = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_wmask = 8'h00;
   logic msg_valid = 1'h0, msg_for_buf0 = 1'h0, msg_rtr = 1'h0;
   logic clr0 = 1'h0, clr1 = 1'h0;
   crbc_pkg::crbc_filt_t msg_filter = 3'h0;
   crbc_pkg::crbc_mode_t rx_mode0, rx_mode1;
   logic [7:0] reg_rdata, pcv = 8'h00;
   logic frame_start_out, glitch_seen, rx_flag0, rx_flag1, load_buf0;
   logic load_buf1, msg_dropped, accept_any0, accept_any1, data_byte_filt;
   logic buf0_full_out, buf0_full_oe, buf1_full_out, buf1_full_oe;
   int errors = 0, total_checks = 0, cyc = 0, sofs = 0, glits = 0;
   crbc_rx_ctrl DUT (.clk, .srst, .can_rx_in, .bus_idle, .sample_point,
      .sof_en, .frame_start_out, .glitch_seen, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_wmask, .reg_rdata, .msg_valid, .msg_for_buf0,
      .msg_filter, .msg_rtr, .rx_flag0, .rx_flag1, .load_buf0, .load_buf1,
      .msg_dropped, .rx_mode0, .rx_mode1, .accept_any0, .accept_any1,
      .data_byte_filt, .buf0_full_out, .buf0_full_oe, .buf1_full_out,
      .buf1_full_oe);
   crbc_flag_model far (.clk, .srst, .load_buf0, .load_buf1, .clr0, .clr1,
      .rx_flag0, .rx_flag1);
   initial begin
      forever #5 clk = ~clk;
   end
   // pulse counters and run limit
   always @(posedge clk) begin
      cyc++;
      if (frame_start_out === 1'h1) sofs++;
      if (glitch_seen === 1'h1) glits++;
      if (cyc == 3000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d, mk);
      reg_addr = a;
      reg_wdata = d;
      reg_wmask = mk;
      reg_wr = 1'h1;
      tick(1);
      reg_wr = 1'h0;
      if (a == 8'h0C) pcv = (pcv & ~mk) | (d & mk);
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      reg_addr = a;
      reg_rd = 1'h1;
      tick(1);
      reg_rd = 1'h0;
      tick(1);
      chk(reg_rdata, exp);
   endtask
   // level bits read as zero only while their pin is an enabled interrupt pin
   function automatic logic [7:0] pc_read(input logic [7:0] p);
      return {2'h0, p[5] & ~(p[3] & p[1]), p[4] & ~(p[2] & p[0]), p[3:0]};
   endfunction
   // the level seen on a released pin is don't-care, so it is folded to 1
   function automatic logic [1:0] pin(input logic en, op, lv, fl);
      return {en, ~en | (op ? ~fl : lv)};
   endfunction
   task automatic chk_pins();
      tick(2);
      chk({4'h0, buf1_full_oe, buf1_full_out | ~buf1_full_oe, buf0_full_oe,
         buf0_full_out | ~buf0_full_oe}, {4'h0, pin(pcv[3], pcv[1], pcv[5],
         rx_flag1), pin(pcv[2], pcv[0], pcv[4], rx_flag0)});
   endtask
   task automatic msg(input logic b0, input logic [2:0] f, input logic rt,
      input logic [7:0] exp);
      msg_for_buf0 = b0;
      msg_filter = f;
      msg_rtr = rt;
      msg_valid = 1'h1;
      tick(1);
      msg_valid = 1'h0;
      chk({5'h00, load_buf0, load_buf1, msg_dropped}, exp);
      tick(1);
   endtask
   task automatic clr(input logic b1);
      clr0 = ~b1;
      clr1 = b1;
      tick(1);
      clr0 = 1'h0;
      clr1 = 1'h0;
   endtask
   // a glitch lifts the line again well before the sample point
   task automatic sof(input logic glitch, en);
      int s, g;
      s = sofs;
      g = glits;
      sof_en = en;
      can_rx_in = 1'h0;
      tick(3);
      can_rx_in = glitch;
      tick(4);
      sample_point = 1'h1;
      tick(1);
      sample_point = 1'h0;
      can_rx_in = 1'h1;
      bus_idle = 1'h0;
      tick(3);
      bus_idle = 1'h1;
      chk(8'(sofs - s), {7'h00, en & ~glitch});
      chk(8'(glits - g), {7'h00, glitch});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(95));
      tick(8);
      srst = 1'h0;
      rdc(8'h0C, 8'h00);
      rdc(8'h60, 8'h00);
      rdc(8'h70, 8'h00);
      wr(8'h33, 8'hFF, 8'hFF);
      rdc(8'h33, 8'h00);
      wr(8'h60, 8'hFF, 8'hFF);
      rdc(8'h60, 8'h66);
      wr(8'h70, 8'hFF, 8'hFF);
      rdc(8'h70, 8'h60);
      $display("test registers done");
      for (int i = 3; i >= 0; i--) begin
         wr(8'h60, 8'(i << 5), 8'h60);
         tick(1);
         wr(8'h70, 8'(i << 5), 8'h60);
         tick(2);
         chk({1'h0, rx_mode0, rx_mode1, accept_any0, accept_any1,
            data_byte_filt}, {1'h0, 2'(i), 2'(i), i == 3, i == 3,
            i == 0});
      end
      $display("test modes done");
      for (int i = 0; i < 24; i++) begin
         wr(8'h0C, 8'($urandom), 8'($urandom));
         rdc(8'h0C, pc_read(pcv));
         chk_pins();
      end
      $display("test pins done");
      wr(8'h0C, 8'h0F, 8'hFF);
      msg(1'h1, 3'h1, 1'h1, 8'h04);
      chk_pins();
      rdc(8'h60, 8'h0F);
      msg(1'h1, 3'h0, 1'h1, 8'h02);
      rdc(8'h60, 8'h0E);
      rdc(8'h70, 8'h08);
      msg(1'h1, 3'h1, 1'h0, 8'h01);
      clr(1'h1);
      msg(1'h0, 3'h5, 1'h1, 8'h02);
      rdc(8'h70, 8'h0D);
      msg(1'h0, 3'h3, 1'h0, 8'h01);
      wr(8'h60, 8'h00, 8'h04);
      clr(1'h1);
      msg(1'h1, 3'h0, 1'h0, 8'h01);
      clr(1'h0);
      chk_pins();
      $display("test messages done");
      sof(1'h0, 1'h1);
      sof(1'h1, 1'h1);
      sof(1'h0, 1'h0);
      $display("test start of frame done");
      conclude();
   end
endmodule // crbc_rx_ctrl_tb
